// [core/rpms_pkg.sv]
package rpms_pkg;
  // ----------------------------------------------------------------
  // Chip status control register layout
  // ----------------------------------------------------------------
  localparam int CSC_STANDBY_BIT = 7;
  localparam int CSC_RF_EN_BIT = 5;
  localparam int CSC_HALF_PWR_BIT = 4;
  localparam int CSC_RX_EN_BIT = 1;
  localparam int CSC_SUPPLY_BIT = 0;
  localparam logic [7:0] CSC_RESET = 8'h01; // 5 V supply selected

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int AUX_TIMEOUT_US = 100;
  localparam int AUX_TIMEOUT_CYC = (AUX_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
  localparam int SETTLE_US = 1500;
  localparam int SETTLE_CYC = (SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Reported power mode codes
  // ----------------------------------------------------------------
  localparam logic [2:0] PM_DOWN = 3'h0;
  localparam logic [2:0] PM_SLEEP = 3'h1;
  localparam logic [2:0] PM_START = 3'h2;
  localparam logic [2:0] PM_STANDBY = 3'h3;
  localparam logic [2:0] PM_MODE1 = 3'h4;
  localparam logic [2:0] PM_MODE2 = 3'h5;
  localparam logic [2:0] PM_MODE34 = 3'h6;

  typedef enum logic [2:0] {
    S_DOWN,
    S_SLEEP,
    S_START,
    S_AUXW,
    S_ACT
  } rpms_state_t;

  // Active mode from the control bits; standby outranks RF bits
  function automatic logic [2:0] rpms_csc_mode(input logic [7:0] c);
    if (c[CSC_STANDBY_BIT]) return PM_STANDBY;
    else if (c[CSC_RF_EN_BIT]) return PM_MODE34;
    else if (c[CSC_RX_EN_BIT]) return PM_MODE2;
    else return PM_MODE1;
  endfunction : rpms_csc_mode
endpackage : rpms_pkg

// [core/rpms_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

module rpms_sequencer import rpms_pkg::*; #(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int TIMEOUT_CYCLES = AUX_TIMEOUT_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic primary_wake_i,
  input wire logic auxiliary_wake_pin_i,
  input wire logic reg_settled_i,
  input wire logic osc_stable_i,
  input wire logic csc_we_i,
  input wire logic [7:0] csc_wdata_i,
  output logic [7:0] csc_rdata_o,
  output logic host_ready_o,
  output logic reg_en_o,
  output logic osc_en_o,
  output logic host_rail_o,
  output logic aux_clk_sel_o,
  output logic host_clock_output_hf_o,
  output logic tx_en_o,
  output logic rx_en_o,
  output logic half_power_o,
  output logic supply_3v_o,
  output logic [2:0] power_mode_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << 20)) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end
  if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << 20)) begin : g_bad_tmo
    $error("TIMEOUT_CYCLES out of range");
  end

  localparam logic [19:0] SETTLE_LAST = 20'(SETTLE_CYCLES - 1);
  localparam logic [19:0] TMO_LAST = 20'(TIMEOUT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Pins and analog flags are asynchronous; a change counts only when
  // stages two and three agree, which also rejects single-cycle glitches.
  logic [3:0] raw_in;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic [3:0] sync3_r;
  logic [3:0] filt_r;
  logic [3:0] filt_nxt;
  assign raw_in = {osc_stable_i, reg_settled_i, auxiliary_wake_pin_i, primary_wake_i};

  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_sync
    always_comb begin
      filt_nxt[gi] = (sync2_r[gi] == sync3_r[gi]) ? sync3_r[gi] : filt_r[gi];
    end
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
        sync3_r[gi] <= 1'b0;
        filt_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= raw_in[gi];
        sync2_r[gi] <= sync1_r[gi];
        sync3_r[gi] <= sync2_r[gi];
        filt_r[gi] <= filt_nxt[gi];
      end
    end
  end

  logic en_f;
  logic aux_f;
  logic settled_f;
  logic osc_f;
  logic aux_rise;
  assign en_f = filt_r[0];
  assign aux_f = filt_r[1];
  assign settled_f = filt_r[2];
  assign osc_f = filt_r[3];
  assign aux_rise = filt_nxt[1] & ~filt_r[1];

  // ----------------------------------------------------------------
  // Power sequencing state
  // ----------------------------------------------------------------
  rpms_state_t state_r;
  rpms_state_t state_nxt;
  logic from_aux_r;
  logic from_aux_nxt;
  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic [7:0] csc_r;
  logic [7:0] csc_nxt;
  logic start_done;

  assign start_done = (cnt_r >= SETTLE_LAST) & settled_f & osc_f;

  // Next state, wake bookkeeping, settle and timeout counters
  always_comb begin
    state_nxt = state_r;
    from_aux_nxt = from_aux_r;
    cnt_nxt = cnt_r;
    case (state_r)
      S_DOWN, S_SLEEP: begin
        cnt_nxt = '0;
        if (en_f) begin
          state_nxt = S_START;
          from_aux_nxt = 1'b0;
        end else if (state_r == S_DOWN && aux_rise) begin
          state_nxt = S_START;
          from_aux_nxt = 1'b1;
        end else if (aux_f && state_r == S_SLEEP) begin
          state_nxt = S_SLEEP;
        end else begin
          state_nxt = S_DOWN;
        end
      end
      S_START: begin
        if (cnt_r < SETTLE_LAST) begin
          cnt_nxt = cnt_r + 20'h00001;
        end
        if (!from_aux_r && !en_f) begin
          // Primary wake withdrawn before the clock switch
          state_nxt = aux_f ? S_SLEEP : S_DOWN;
        end else if (start_done) begin
          cnt_nxt = '0;
          state_nxt = (from_aux_r && !en_f) ? S_AUXW : S_ACT;
        end
      end
      S_AUXW: begin
        cnt_nxt = cnt_r + 20'h00001;
        if (en_f) begin
          state_nxt = S_ACT;
        end else if (cnt_r >= TMO_LAST) begin
          state_nxt = S_DOWN;
        end
      end
      S_ACT: begin
        cnt_nxt = '0;
        if (!en_f) begin
          state_nxt = aux_f ? S_SLEEP : S_DOWN;
        end
      end
      default: begin
        state_nxt = S_DOWN;
        cnt_nxt = '0;
      end
    endcase
  end

  // Control register; contents are lost with the supply in power-down
  always_comb begin
    csc_nxt = csc_r;
    if (state_nxt == S_DOWN) begin
      csc_nxt = CSC_RESET;
    end else if (csc_we_i && host_ready_o) begin
      csc_nxt = csc_wdata_i;
    end
  end

  // ----------------------------------------------------------------
  // Output decode, registered so each output leaves a flip-flop
  // ----------------------------------------------------------------
  logic ready_nxt;
  logic reg_en_nxt;
  logic rail_nxt;
  logic aux_clk_nxt;
  logic hf_nxt;
  logic tx_nxt;
  logic rx_nxt;
  logic [2:0] mode_nxt;

  always_comb begin
    ready_nxt = 1'b0;
    reg_en_nxt = 1'b0;
    rail_nxt = 1'b0;
    aux_clk_nxt = 1'b0;
    hf_nxt = 1'b0;
    tx_nxt = 1'b0;
    rx_nxt = 1'b0;
    mode_nxt = PM_DOWN;
    case (state_nxt)
      S_SLEEP: begin
        rail_nxt = 1'b1;
        aux_clk_nxt = 1'b1;
        mode_nxt = PM_SLEEP;
      end
      S_START: begin
        reg_en_nxt = 1'b1;
        rail_nxt = 1'b1;
        aux_clk_nxt = 1'b1; // Host runs on the slow clock meanwhile
        mode_nxt = PM_START;
      end
      S_AUXW, S_ACT: begin
        reg_en_nxt = 1'b1;
        rail_nxt = 1'b1;
        hf_nxt = 1'b1;
        ready_nxt = 1'b1;
        mode_nxt = rpms_csc_mode(csc_nxt);
        tx_nxt = (mode_nxt == PM_MODE34);
        rx_nxt = (mode_nxt == PM_MODE34) || (mode_nxt == PM_MODE2);
      end
      default: begin
        mode_nxt = PM_DOWN;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= S_DOWN;
      from_aux_r <= 1'b0;
      cnt_r <= '0;
      csc_r <= CSC_RESET;
      csc_rdata_o <= CSC_RESET;
      host_ready_o <= 1'b0;
      reg_en_o <= 1'b0;
      osc_en_o <= 1'b0;
      host_rail_o <= 1'b0;
      aux_clk_sel_o <= 1'b0;
      host_clock_output_hf_o <= 1'b0;
      tx_en_o <= 1'b0;
      rx_en_o <= 1'b0;
      half_power_o <= 1'b0;
      supply_3v_o <= 1'b0;
      power_mode_o <= PM_DOWN;
    end else begin
      state_r <= state_nxt;
      from_aux_r <= from_aux_nxt;
      cnt_r <= cnt_nxt;
      csc_r <= csc_nxt;
      csc_rdata_o <= csc_nxt;
      host_ready_o <= ready_nxt;
      reg_en_o <= reg_en_nxt;
      osc_en_o <= reg_en_nxt;
      host_rail_o <= rail_nxt;
      aux_clk_sel_o <= aux_clk_nxt;
      host_clock_output_hf_o <= hf_nxt;
      tx_en_o <= tx_nxt;
      rx_en_o <= rx_nxt;
      half_power_o <= tx_nxt & csc_nxt[CSC_HALF_PWR_BIT];
      supply_3v_o <= ~csc_nxt[CSC_SUPPLY_BIT];
      power_mode_o <= mode_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  primary_wake_a: assert property ((state_r == S_DOWN || state_r == S_SLEEP) && en_f
    |=> state_r == S_START && reg_en_o && osc_en_o)
    else $error("primary wake did not start supplies");
  sleep_outputs_a: assert property (state_r == S_SLEEP
    |-> host_rail_o && aux_clk_sel_o && !host_clock_output_hf_o && !tx_en_o && !rx_en_o)
    else $error("sleep outputs wrong");
  aux_edge_a: assert property (state_r == S_DOWN && !en_f && aux_rise
    |=> state_r == S_START && from_aux_r && osc_en_o)
    else $error("auxiliary edge did not start up");
  aux_timeout_a: assert property (state_r == S_AUXW && !en_f && cnt_r == TMO_LAST
    |=> state_r == S_DOWN && !host_rail_o)
    else $error("auxiliary wake timeout missed");
  aux_bound_a: assert property (state_r == S_AUXW |-> cnt_r <= TMO_LAST)
    else $error("auxiliary wait overran");
  stay_active_a: assert property (state_r == S_AUXW && en_f ##1 en_f
    |-> state_r == S_ACT)
    else $error("primary wake did not hold device active");
  clk_switch_a: assert property ($rose(host_clock_output_hf_o)
    |-> $past(state_r) == S_START && $past(settled_f) && $past(osc_f)
        && $past(cnt_r) >= SETTLE_LAST)
    else $error("clock switched before settling");
  write_gate_a: assert property (csc_we_i && !host_ready_o && state_r != S_DOWN
    && state_nxt != S_DOWN |=> csc_r == $past(csc_r))
    else $error("write taken while not ready");
  mode_select_a: assert property (state_r == S_ACT |-> power_mode_o == rpms_csc_mode(csc_r))
    else $error("mode not taken from control bits");
  standby_a: assert property (state_r == S_ACT && csc_r[CSC_STANDBY_BIT]
    |-> power_mode_o == PM_STANDBY && !tx_en_o && !rx_en_o && osc_en_o)
    else $error("standby wrong");
  mode1_a: assert property (state_r == S_ACT && csc_r[7:5] == 3'h0 && !csc_r[1]
    |-> power_mode_o == PM_MODE1 && !tx_en_o && !rx_en_o)
    else $error("mode 1 wrong");
  mode2_a: assert property (state_r == S_ACT && !csc_r[7] && !csc_r[5] && csc_r[1]
    |-> power_mode_o == PM_MODE2 && !tx_en_o && rx_en_o)
    else $error("mode 2 wrong");
  rf_full_a: assert property (state_r == S_ACT && !csc_r[7] && csc_r[5]
    |-> tx_en_o && rx_en_o && half_power_o == csc_r[4])
    else $error("RF section wrong");
  power_down_a: assert property (state_r == S_DOWN
    |-> !reg_en_o && !osc_en_o && !host_rail_o && !aux_clk_sel_o
        && !host_clock_output_hf_o && !tx_en_o && !rx_en_o)
    else $error("power-down outputs wrong");
  supply_sel_a: assert property (supply_3v_o == !csc_r[CSC_SUPPLY_BIT])
    else $error("supply select wrong");
  half_power_a: assert property (half_power_o |-> tx_en_o && csc_r[CSC_HALF_PWR_BIT])
    else $error("half power outside RF mode");

  wake_cover_c: cover property (state_r == S_START ##1 state_r == S_ACT);
  aux_timeout_c: cover property (state_r == S_AUXW ##1 state_r == S_DOWN);
  aux_confirm_c: cover property (state_r == S_AUXW ##1 state_r == S_ACT);
  sleep_c: cover property (state_r == S_ACT ##1 state_r == S_SLEEP);

endmodule : rpms_sequencer

`default_nettype wire

// [testbench/rpms_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host controller driving the wake pins and the control register
// ----------------------------------------------------------------
module rpms_host_model #(
  parameter int GAP_CYCLES = 125000
) (
  input wire logic clk_i,
  output var logic primary_wake_o,
  output var logic aux_wake_o,
  output var logic csc_we_o,
  output var logic [7:0] csc_wdata_o
);
  int cyc = 0;
  int last_cyc = 0;
  logic last_aux = 1'b0;

  // Auxiliary pin rests low until a scenario asks for it
  initial begin
    primary_wake_o = 1'b0;
    aux_wake_o = 1'b0;
    csc_we_o = 1'b0;
    csc_wdata_o = 8'h00;
  end

  // Free cycle count for pin spacing
  always @(posedge clk_i) cyc <= cyc + 1;

  // Switching to the other pin waits out the spacing, so both never rise together
  task automatic drive_pin(input logic aux, input logic v);
    if (aux != last_aux) begin
      while (cyc - last_cyc < GAP_CYCLES) @(posedge clk_i);
    end
    @(posedge clk_i);
    if (aux) aux_wake_o <= v;
    else primary_wake_o <= v;
    last_aux = aux;
    last_cyc = cyc;
  endtask : drive_pin

  // Data is scrambled after the strobe so a stale value never looks valid
  task automatic write_csc(input logic [7:0] d);
    @(posedge clk_i);
    csc_we_o <= 1'b1;
    csc_wdata_o <= d;
    @(posedge clk_i);
    csc_we_o <= 1'b0;
    csc_wdata_o <= ~d;
  endtask : write_csc
endmodule : rpms_host_model

`default_nettype wire

// [testbench/test_reader_power_mode_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none

module test_reader_power_mode_sequencer import rpms_pkg::*;;
  localparam int TO = 40;
  logic clk_i, rst_i, pw, aw, settled, stable, we;
  logic [7:0] wd, csc;
  logic ready, reg_en, osc_en, rail, aux_sel, hf, tx, rx, half, v3;
  logic [2:0] mode;
  int mismatches = 0;
  int comparisons = 0;
  int n;
  logic [7:0] vals [11] = '{8'h21, 8'h20, 8'h31, 8'h30, 8'h03, 8'h02, 8'h01, 8'h00,
                             8'h81, 8'h80, 8'ha1};
  logic [7:0] v;
  logic [2:0] m;

  rpms_host_model #(.GAP_CYCLES(20)) rpms_host_model_i (.clk_i(clk_i), .primary_wake_o(pw),
    .aux_wake_o(aw), .csc_we_o(we), .csc_wdata_o(wd));
  rpms_sequencer #(.SETTLE_CYCLES(8), .TIMEOUT_CYCLES(TO)) rpms_sequencer_i (.clk_i(clk_i),
    .rst_i(rst_i), .primary_wake_i(pw), .auxiliary_wake_pin_i(aw), .reg_settled_i(settled),
    .osc_stable_i(stable), .csc_we_i(we), .csc_wdata_i(wd), .csc_rdata_o(csc),
    .host_ready_o(ready), .reg_en_o(reg_en), .osc_en_o(osc_en), .host_rail_o(rail),
    .aux_clk_sel_o(aux_sel), .host_clock_output_hf_o(hf), .tx_en_o(tx), .rx_en_o(rx),
    .half_power_o(half), .supply_3v_o(v3), .power_mode_o(mode));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Bounded wait: 0 mode, 1 fast clock, 2 regulators
  task automatic wait_for(input int sel, input logic [2:0] w, input int bound, output int k);
    logic hit;
    k = 0;
    hit = 1'b0;
    while (!hit) begin
      @(posedge clk_i);
      #1;
      k++;
      case (sel)
        0: hit = (mode === w);
        1: hit = (hf === w[0]);
        default: hit = (reg_en === w[0]);
      endcase
      if (k > bound) begin
        chk(8'h00, 8'h01, "wait ran out");
        test_done();
      end
    end
  endtask : wait_for

  // Flags follow the analog side: both drop while powered down
  task automatic flags(input logic s, input logic o);
    @(posedge clk_i);
    settled <= s;
    stable <= o;
  endtask : flags

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    settled = 1'b0;
    stable = 1'b0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(csc, 8'h01, "reset csc");
    chk({2'b00, mode, reg_en, ready, v3}, 8'h00, "reset outputs");
    rpms_host_model_i.write_csc(8'h21);
    #1;
    chk(csc, 8'h01, "write before ready");
    rpms_host_model_i.drive_pin(1'b0, 1'b1);
    wait_for(2, 3'h1, 10, n);
    chk({4'h0, osc_en, aux_sel, hf, ready}, 8'h0c, "startup outputs");
    flags(1'b1, 1'b0);
    repeat (20) @(posedge clk_i);
    #1;
    chk({3'h0, hf, ready, mode}, {5'h00, PM_START}, "unstable oscillator");
    // Writes during start-up are dropped: host clock still slow
    rpms_host_model_i.write_csc(8'h21);
    #1;
    chk(csc, 8'h01, "write while starting");
    flags(1'b1, 1'b1);
    wait_for(1, 3'h1, 40, n);
    chk({3'h0, aux_sel, ready, mode}, {5'h01, PM_MODE1}, "fast clock up");
    // Mode table, expectations built from the bit meanings
    for (int i = 0; i < 11; i++) begin
      v = vals[i];
      m = v[7] ? PM_STANDBY : v[5] ? PM_MODE34 : v[1] ? PM_MODE2 : PM_MODE1;
      rpms_host_model_i.write_csc(v);
      #1;
      chk(csc, v, "csc readback");
      chk({tx, rx, half, v3, 1'b0, mode}, {~v[7] & v[5], ~v[7] & (v[5] | v[1]),
          ~v[7] & v[5] & v[4], ~v[0], 1'b0, m}, "mode decode");
    end
    rpms_host_model_i.write_csc(8'h21);
    rpms_host_model_i.drive_pin(1'b1, 1'b1);
    rpms_host_model_i.drive_pin(1'b0, 1'b0);
    wait_for(0, PM_SLEEP, 20, n);
    chk({2'b00, rail, aux_sel, hf, tx, rx, ready}, 8'h30, "sleep outputs");
    rpms_host_model_i.drive_pin(1'b1, 1'b0);
    wait_for(0, PM_DOWN, 20, n);
    chk({3'h0, rail, aux_sel, reg_en, osc_en, hf}, 8'h00, "down outputs");
    chk(csc, 8'h01, "down csc");
    flags(1'b0, 1'b0);
    // Wake by the auxiliary pin alone, then let it time out
    rpms_host_model_i.drive_pin(1'b1, 1'b1);
    wait_for(2, 3'h1, 10, n);
    chk({5'h00, mode}, {5'h00, PM_START}, "aux startup");
    flags(1'b1, 1'b1);
    wait_for(1, 3'h1, 40, n);
    chk({7'h00, ready}, 8'h01, "aux ready");
    wait_for(2, 3'h0, TO + 20, n);
    chk(8'(n >= TO - 1 && n <= TO + 1), 8'h01, "timeout span");
    chk({5'h00, mode}, {5'h00, PM_DOWN}, "timeout mode");
    repeat (10) @(posedge clk_i);
    #1;
    chk({7'h00, reg_en}, 8'h00, "held aux no rewake");
    flags(1'b0, 1'b0);
    rpms_host_model_i.drive_pin(1'b1, 1'b0);
    repeat (6) @(posedge clk_i);
    // Second aux wake, confirmed by the primary pin
    rpms_host_model_i.drive_pin(1'b1, 1'b1);
    wait_for(2, 3'h1, 10, n);
    flags(1'b1, 1'b1);
    rpms_host_model_i.drive_pin(1'b0, 1'b1);
    repeat (TO + 20) @(posedge clk_i);
    #1;
    chk({reg_en, ready, hf, 2'b00, mode}, {5'h1c, PM_MODE1}, "stays active");
    test_done();
  end
endmodule : test_reader_power_mode_sequencer

`default_nettype wire
